// ==== src/sacs_cfg.svh ====
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH
// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define SACS_FRAME_16 5'd16
`define SACS_FRAME_14 5'd14
`define SACS_FRAME_12 5'd12
`define SACS_HOLD_EDGE 5'd3
`define SACS_LEAD_ZEROS 4
`define SACS_RES_W 12
`define SACS_SHIFT_W 16
`define SACS_CNT_W 5
// ----------------------------------------
// Host timing (ns and core_clk cycles)
// ----------------------------------------
`define SACS_CLK_NS 4
`define SACS_SCLK_HALF_NS 80
`define SACS_SCLK_HALF_CYC 6'd20
`define SACS_QUIET_NS 60
`define SACS_QUIET_CYC 6'd15
`define SACS_DIV_W 6
`endif

// ==== src/sacs_device.sv ====
`timescale 1ns/1ps
`include "sacs_cfg.svh"
// Summary of operation
// - Power down automatically after every conversion.
// - Select fall wakes part, starts tracking.
// - Select fall also starts the conversion.
// - Third clock falling edge returns to hold.
// - Wide variant ends on 16th edge.
// - Middle variant ends on 14th edge.
// - Narrow variant ends on 12th edge.
// - Early select rise forces immediate power-down.
// - Early rise aborts, output goes high-Z.
// - Abort window ends at variant's last edge.
// - Host should raise select after conversion.
// - Host runs one dummy conversion after power-up; sacs_host runs no dummy frame and waits for start.
// - Host waits quiet interval before next frame.
// - Duration equals cycle count times clock period.
// - Four zeros then result, MSB first.
// - Select fall gives first zero; falls shift.
// - Select fall enables the result output.
module sacs_device
  import sacs_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  sacs_link_if.device link, // Serial link
  input wire sacs_variant_t variant, // Frame length select
  input wire logic [`SACS_RES_W-1:0] sample_value, // Digitised input
  output logic powered_up, // Analog section awake
  output logic tracking, // Track-and-hold in track
  output logic frame_done // One-cycle pulse on full frame
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sel_sync_reg, sel_sync_next;
  logic [1:0] sclk_sync_reg, sclk_sync_next;
  logic sel_prev_reg, sel_prev_next;
  logic sclk_prev_reg, sclk_prev_next;

  // Two stages before any logic looks at the pins
  // Pins may move at any time relative to core_clk; the second
  // flop gives the first a full cycle to settle.
  // Cost: each link event is seen two core_clk edges late,
  // so every link half period must span several core_clk cycles.
  always_comb begin
    sel_sync_next = {sel_sync_reg[0], link.select_n};
    sclk_sync_next = {sclk_sync_reg[0], link.sclk};
    sel_prev_next = sel_sync_reg[1];
    sclk_prev_next = sclk_sync_reg[1];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle pin levels, so no false edge follows reset
      sel_sync_reg <= 2'h3;
      sclk_sync_reg <= 2'h3;
      sel_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else begin
      sel_sync_reg <= sel_sync_next;
      sclk_sync_reg <= sclk_sync_next;
      sel_prev_reg <= sel_prev_next;
      sclk_prev_reg <= sclk_prev_next;
    end
  end

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  // Edges come from the second stage and its delayed copy only;
  // the first stage is never read here.
  logic sel_fall, sel_high, sclk_fall;
  assign sel_fall = sel_prev_reg & ~sel_sync_reg[1];
  assign sel_high = sel_sync_reg[1];
  assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg[1];

  // ----------------------------------------
  // Variant decode
  // ----------------------------------------
  // Frame length decode, shared by end-of-frame test
  // Unused code falls back to the widest frame
  function automatic logic [`SACS_CNT_W-1:0] frame_len(input sacs_variant_t v);
    case (v)
      SACS_VAR_14: frame_len = `SACS_FRAME_14;
      SACS_VAR_12: frame_len = `SACS_FRAME_12;
      default: frame_len = `SACS_FRAME_16;
    endcase
  endfunction

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // Frame timeline, in link events:
  //   select fall: wake, track, drive first zero, clear count
  //   falls 1 and 2: second and third zero
  //   fall 3: track-and-hold back to hold
  //   later falls: result bits, MSB first
  //   fall N: release line, power down, pulse frame_done
  //   select rise before fall N: abort, release line
  // Limitation: a select pulse shorter than one core_clk cycle
  // may be lost in the synchroniser.

  sacs_dev_state_t state_reg, state_next;
  logic [`SACS_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`SACS_SHIFT_W-1:0] shift_reg, shift_next;
  logic track_reg, track_next;
  logic oe_reg, oe_next;
  logic done_reg, done_next;
  logic [`SACS_SHIFT_W-1:0] frame_word;

  // Result left-aligned after leading zeros; narrow frames drop the low result bits
  always_comb begin
    frame_word = '0;
    frame_word[`SACS_SHIFT_W-`SACS_LEAD_ZEROS-1 -: `SACS_RES_W] = sample_value;
  end

  // Next-state logic; frame_done defaults low so it pulses once
  // Abort has priority over a clock fall seen in the same cycle
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    track_next = track_reg;
    oe_next = oe_reg;
    done_next = 1'b0;
    case (state_reg)
      SACS_DOWN: begin
        if (sel_fall) begin
          state_next = SACS_CONV;
          cnt_next = '0;
          track_next = 1'b1;
          oe_next = 1'b1;
          shift_next = frame_word;
        end
      end
      SACS_CONV: begin
        if (sel_high) begin
          // Abort mid-frame: power down and release the line
          state_next = SACS_DOWN;
          track_next = 1'b0;
          oe_next = 1'b0;
          shift_next = '0;
        end else if (sclk_fall) begin
          // Compares use the new count: this fall is edge cnt_reg+1
          cnt_next = cnt_reg + 1'b1;
          shift_next = {shift_reg[`SACS_SHIFT_W-2:0], 1'b0};
          if (cnt_reg + 1'b1 == `SACS_HOLD_EDGE) begin
            track_next = 1'b0;
          end
          if (cnt_reg + 1'b1 == frame_len(variant)) begin
            // Auto power-down on the last counted edge
            state_next = SACS_DONE;
            oe_next = 1'b0;
            track_next = 1'b0;
            shift_next = '0;
            done_next = 1'b1;
          end
        end
      end
      SACS_DONE: begin
        // Clock edges ignored until select rises
        if (sel_high) begin
          state_next = SACS_DOWN;
        end
      end
      default: begin
        state_next = SACS_DOWN;
        oe_next = 1'b0;
        track_next = 1'b0;
        shift_next = '0;
      end
    endcase
  end

  // Sequencer registers only; decisions sit in the block above
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SACS_DOWN;
      cnt_reg <= '0;
      shift_reg <= '0;
      track_reg <= 1'b0;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      track_reg <= track_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Shift word is cleared on release, so the line rests low;
  // a receiver that samples after release reads zeros.
  assign link.serial_result_out = shift_reg[`SACS_SHIFT_W-1];
  // Drive enable straight from its flop: no glitch on the pin
  assign link.serial_result_oe = oe_reg;
  // Awake only while a conversion runs
  assign powered_up = (state_reg == SACS_CONV);
  assign tracking = track_reg;
  assign frame_done = done_reg;
endmodule

// ==== src/sacs_host.sv ====
`timescale 1ns/1ps
`include "sacs_cfg.svh"
module sacs_host
  import sacs_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  sacs_link_if.host link, // Serial link
  input wire sacs_variant_t variant, // Frame length to run
  input wire logic start, // Request one conversion
  output logic busy, // Frame or quiet time running
  output logic [`SACS_SHIFT_W-1:0] result, // Captured frame word
  output logic result_valid // One-cycle pulse with result
);
  // ----------------------------------------
  // Frame generator
  // ----------------------------------------
  logic [1:0] dat_sync_reg, dat_sync_next;
  sacs_host_state_t state_reg, state_next;
  logic [`SACS_DIV_W-1:0] div_reg, div_next;
  logic [`SACS_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`SACS_SHIFT_W-1:0] shift_reg, shift_next;
  logic [`SACS_SHIFT_W-1:0] result_reg, result_next;
  logic valid_reg, valid_next;
  logic sel_reg, sel_next;
  logic sclk_reg, sclk_next;
  logic [`SACS_CNT_W-1:0] len;

  always_comb begin
    case (variant)
      SACS_VAR_14: len = `SACS_FRAME_14;
      SACS_VAR_12: len = `SACS_FRAME_12;
      default: len = `SACS_FRAME_16;
    endcase
  end

  // Sclk made by divider; data sampled on rising sclk, after sync delay
  always_comb begin
    dat_sync_next = {dat_sync_reg[0], link.serial_result_out};
    state_next = state_reg;
    div_next = div_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    result_next = result_reg;
    valid_next = 1'b0;
    sel_next = sel_reg;
    sclk_next = sclk_reg;
    case (state_reg)
      SACS_H_IDLE: begin
        if (start) begin
          state_next = SACS_H_LOW;
          sel_next = 1'b0;
          sclk_next = 1'b1;
          div_next = '0;
          cnt_next = '0;
        end
      end
      SACS_H_LOW: begin
        div_next = div_reg + 1'b1;
        if (div_reg == `SACS_SCLK_HALF_CYC) begin
          sclk_next = 1'b0;
          div_next = '0;
          cnt_next = cnt_reg + 1'b1;
          state_next = SACS_H_HIGH;
        end
      end
      SACS_H_HIGH: begin
        div_next = div_reg + 1'b1;
        if (div_reg == `SACS_SCLK_HALF_CYC) begin
          sclk_next = 1'b1;
          div_next = '0;
          shift_next = {shift_reg[`SACS_SHIFT_W-2:0], dat_sync_reg[1]};
          if (cnt_reg == len) begin
            // Raise select after frame to save power
            sel_next = 1'b1;
            result_next = {shift_reg[`SACS_SHIFT_W-2:0], dat_sync_reg[1]};
            valid_next = 1'b1;
            state_next = SACS_H_QUIET;
          end else begin
            state_next = SACS_H_LOW;
          end
        end
      end
      SACS_H_QUIET: begin
        // Hold off the next frame for the quiet interval
        div_next = div_reg + 1'b1;
        if (div_reg == `SACS_QUIET_CYC) begin
          state_next = SACS_H_IDLE;
          div_next = '0;
        end
      end
      default: begin
        state_next = SACS_H_IDLE;
        sel_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dat_sync_reg <= 2'h0;
      state_reg <= SACS_H_IDLE;
      div_reg <= '0;
      cnt_reg <= '0;
      shift_reg <= '0;
      result_reg <= '0;
      valid_reg <= 1'b0;
      sel_reg <= 1'b1;
      sclk_reg <= 1'b1;
    end else begin
      dat_sync_reg <= dat_sync_next;
      state_reg <= state_next;
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
      sel_reg <= sel_next;
      sclk_reg <= sclk_next;
    end
  end

  assign link.select_n = sel_reg;
  assign link.sclk = sclk_reg;
  assign busy = (state_reg != SACS_H_IDLE);
  assign result = result_reg;
  assign result_valid = valid_reg;
endmodule

// ==== src/sacs_link_if.sv ====
`timescale 1ns/1ps
interface sacs_link_if;
  logic select_n; // Active-low frame select, host drives
  logic sclk; // Serial clock, host drives
  logic serial_result_out; // Result bit from device
  logic serial_result_oe; // High while device drives the line
  modport device (input select_n, input sclk, output serial_result_out,
    output serial_result_oe);
  modport host (output select_n, output sclk, input serial_result_out,
    input serial_result_oe);
endinterface

// ==== src/sacs_pkg.sv ====
package sacs_pkg;
  // Variant selection
  typedef enum logic [1:0] {
    SACS_VAR_16 = 2'h0,
    SACS_VAR_14 = 2'h1,
    SACS_VAR_12 = 2'h2
  } sacs_variant_t;
  // Device frame states, one-hot
  typedef enum logic [2:0] {
    SACS_DOWN = 3'h1,
    SACS_CONV = 3'h2,
    SACS_DONE = 3'h4
  } sacs_dev_state_t;
  // Host states, one-hot
  typedef enum logic [3:0] {
    SACS_H_IDLE = 4'h1,
    SACS_H_LOW = 4'h2,
    SACS_H_HIGH = 4'h4,
    SACS_H_QUIET = 4'h8
  } sacs_host_state_t;
endpackage

// ==== verif/sacs_link_chk.sv ====
`timescale 1ns/1ps
// ------------------------
// Link protocol checks
// ------------------------
module sacs_link_chk (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic select_n, // Frame select
  input wire logic sclk, // Link clock
  input wire logic serial_result_out, // Data bit
  input wire logic serial_result_oe // Drive enable
);
  logic [4:0] fall_reg;
  logic [4:0] fall_next;
  logic [4:0] gap_reg;
  logic [4:0] gap_next;
  logic sclk_reg;
  logic edge_fall;
  logic oe_q;
  logic [4:0] rel_reg;
  logic [4:0] rel_next;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Falls in this frame; gap saturates so it cannot wrap
  always_comb begin
    edge_fall = sclk_reg & ~sclk;
    fall_next = select_n ? 5'h0 : fall_reg + {4'h0, edge_fall};
    gap_next = edge_fall ? 5'h0 : gap_reg + {4'h0, gap_reg != 5'h1f};
    // Cycles since the line was released; saturates
    rel_next = (oe_q & ~serial_result_oe) ? 5'h0 : rel_reg + {4'h0, rel_reg != 5'h1f};
  end
  // Helper registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fall_reg <= 5'h0;
      gap_reg <= 5'h1f;
      sclk_reg <= 1'b1;
      rel_reg <= 5'h1f;
      oe_q <= 1'b0;
    end else begin
      fall_reg <= fall_next;
      gap_reg <= gap_next;
      sclk_reg <= sclk;
      rel_reg <= rel_next;
      oe_q <= serial_result_oe;
    end
  end
  a_wake_drive: assert property ($fell(select_n) |-> ##[2:6] serial_result_oe)
    else $error("output not driven after select fall");
  a_abort_release: assert property ($rose(select_n) |-> ##[0:6] !serial_result_oe)
    else $error("output still driven after select rise");
  a_idle_quiet: assert property (select_n [*6] |-> !serial_result_oe)
    else $error("output driven while deselected");
  a_shift_edge: assert property (serial_result_oe && $past(serial_result_oe)
    && $changed(serial_result_out) |-> gap_reg < 5'h9)
    else $error("data changed away from a clock fall");
  a_lead_zeros: assert property (serial_result_oe && fall_reg < 5'h4 |-> !serial_result_out)
    else $error("leading bit not zero");
  a_frame_len: assert property ($fell(serial_result_oe) |-> select_n
    || (fall_reg >= 5'hc && fall_reg <= 5'h10))
    else $error("frame ended at a wrong fall count");
  a_stay_down: assert property ($fell(serial_result_oe) |=> !serial_result_oe [*8])
    else $error("output came back after frame end");
  a_quiet_gap: assert property ($rose(select_n) |-> select_n [*8])
    else $error("select lowered too soon");
  a_quiet_time: assert property ($fell(select_n) |-> rel_reg >= 5'hf)
    else $error("select lowered inside quiet time");
  a_raise_after: assert property ($fell(serial_result_oe) |-> ##[0:40] select_n)
    else $error("select not raised after frame");
endmodule

// ==== verif/serial_adc_conversion_sequencer_tb.sv ====
`timescale 1ns/1ps
module serial_adc_conversion_sequencer_tb;
  import sacs_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  sacs_variant_t variant = SACS_VAR_16;
  sacs_variant_t variant2 = SACS_VAR_16;
  logic [11:0] sample_value = 12'h0;
  logic [11:0] sample2 = 12'h0;
  logic busy, result_valid, powered_up, tracking, frame_done, powered2, tracking2, done2;
  logic [15:0] result;
  logic sclk_q = 1'b1;
  logic trk_q = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  int done_cnt = 0;
  int done_cnt2 = 0;
  int fc = 0;
  int hold_fall = 0;
  sacs_link_if link ();
  sacs_link_if link2 ();
  sacs_host sacs_host_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .variant(variant), .start(start), .busy(busy), .result(result),
    .result_valid(result_valid));
  sacs_device sacs_device_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .variant(variant), .sample_value(sample_value), .powered_up(powered_up),
    .tracking(tracking), .frame_done(frame_done));
  // Second device faces the bench, which breaks the frame on purpose
  sacs_device sacs_device_i2 (.core_clk(core_clk), .reset_n(reset_n), .link(link2),
    .variant(variant2), .sample_value(sample2), .powered_up(powered2),
    .tracking(tracking2), .frame_done(done2));
  sacs_link_chk sacs_link_chk_i (.core_clk(core_clk), .reset_n(reset_n),
    .select_n(link.select_n), .sclk(link.sclk), .serial_result_out(link.serial_result_out),
    .serial_result_oe(link.serial_result_oe));
  // Clock
  initial forever #2 core_clk = ~core_clk;
  // Frame ends, link clock falls in frame, and the fall that ends tracking
  always @(posedge core_clk) begin
    sclk_q <= link.sclk;
    trk_q <= tracking;
    done_cnt <= done_cnt + int'(frame_done === 1'b1);
    done_cnt2 <= done_cnt2 + int'(done2 === 1'b1);
    fc <= fc + int'(sclk_q === 1'b1 && link.sclk === 1'b0 && link.select_n === 1'b0);
    if (trk_q === 1'b1 && tracking === 1'b0) hold_fall <= fc;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for the result pulse or for the host to go idle
  task automatic wait_for(input bit want_idle);
    for (int i = 0; i < 2000; i++) begin
      @(posedge core_clk);
      if (want_idle ? busy === 1'b0 : result_valid === 1'b1) return;
    end
    bad_count++;
    $display("[ERR] %0t timeout", $time);
    test_done();
  endtask
  // Half a link clock period on the second link, 160 ns period
  task automatic half(input logic s);
    link2.sclk <= s;
    repeat (20) @(posedge core_clk);
  endtask
  task automatic t_frame(input sacs_variant_t v, input logic [11:0] sv, input int n);
    int f0, d0;
    logic [15:0] m;
    variant <= v;
    sample_value <= sv;
    @(posedge core_clk);
    f0 = fc;
    d0 = done_cnt;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    wait_for(1'b0);
    // First zero is missed: the host's first edge after select is a fall
    m = 16'((1 << (n - 1)) - 1);
    check((result >> 1) & m, ({4'h0, sv} >> (16 - n)) & m, "data");
    wait_for(1'b1);
    check(16'(fc - f0), 16'(n), "falls");
    check(16'(hold_fall - f0), 16'h3, "hold");
    check(16'(done_cnt - d0), 16'h1, "done");
    check(16'({powered_up, tracking, link.serial_result_oe}), 16'h0, "asleep");
    $display("frame %0d end", n);
  endtask
  task automatic t_abort(input sacs_variant_t v, input int k);
    int d0;
    variant2 <= v;
    d0 = done_cnt2;
    link2.select_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(16'({powered2, tracking2, link2.serial_result_oe}), 16'h7, "wake");
    repeat (k) begin
      half(1'b0);
      half(1'b1);
    end
    link2.select_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(16'({powered2, tracking2, link2.serial_result_oe}), 16'h0, "abort");
    check(16'(done_cnt2 - d0), 16'h0, "no done");
    repeat (16) @(posedge core_clk);
    $display("abort %0d end", k);
  endtask
  task automatic t_wire(input sacs_variant_t v, input logic [11:0] sv, input int n);
    int d0;
    logic [15:0] got;
    variant2 <= v;
    sample2 <= sv;
    d0 = done_cnt2;
    got = 16'h0;
    link2.select_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    // Three extra falls after the frame must be ignored
    for (int i = 0; i < n + 3; i++) begin
      if (i < n) got = {got[14:0], link2.serial_result_out};
      check(16'(link2.serial_result_oe), 16'(i < n), "drive");
      half(1'b0);
      half(1'b1);
    end
    check(got, {4'h0, sv} >> (16 - n), "wire");
    check(16'({powered2, link2.serial_result_oe}), 16'h0, "extra");
    check(16'(done_cnt2 - d0), 16'h1, "one done");
    link2.select_n <= 1'b1;
    half(1'b0);
    check(16'({powered2, link2.serial_result_oe}), 16'h0, "idle clk");
    half(1'b1);
    $display("wire %0d end", n);
  endtask
  // Main sequence
  initial begin
    @(posedge core_clk);
    link2.select_n <= 1'b1;
    link2.sclk <= 1'b1;
    repeat (15) @(posedge core_clk);
    reset_n <= 1'b1;
    t_frame(SACS_VAR_16, 12'h000, 16);
    t_frame(SACS_VAR_16, 12'ha5c, 16);
    t_frame(SACS_VAR_14, 12'h3f1, 14);
    t_frame(SACS_VAR_12, 12'hfff, 12);
    t_abort(SACS_VAR_16, 15);
    t_abort(SACS_VAR_14, 13);
    t_abort(SACS_VAR_12, 2);
    t_wire(SACS_VAR_16, 12'h9c3, 16);
    t_wire(SACS_VAR_14, 12'h5a5, 14);
    t_wire(SACS_VAR_12, 12'hc3c, 12);
    test_done();
  end
endmodule
